// File: verilog/charger_ctrl_map.svh
`ifndef CHARGER_CTRL_MAP_SVH
`define CHARGER_CTRL_MAP_SVH

// Register addresses and reset values.
`define ADDR_CTRL_TWO      8'h06
`define ADDR_CTRL_THREE    8'h07
`define RST_CTRL_TWO       8'hE6
`define RST_CTRL_THREE     8'h4C

// Bit positions in the third control register.
`define B3_DETECT          7
`define B3_HALF            6
`define B3_OFF             5
`define B3_WITH_ADAPTER    4
`define B3_DELAY           3
`define B3_RST_EN          2

// Input overvoltage thresholds in mV: 5850, 6400, 11000, 14200.
`define OVP_MV_0           16'h16DA
`define OVP_MV_1           16'h1900
`define OVP_MV_2           16'h2AF8
`define OVP_MV_3           16'h3778

// Boost voltages in mV: 4600, 4750, 5000, 5150.
`define BOOST_MV_0         16'h11F8
`define BOOST_MV_1         16'h128E
`define BOOST_MV_2         16'h1388
`define BOOST_MV_3         16'h141E

// Input voltage floor: 3900 mV base, 100 mV per code step.
`define FLOOR_BASE_MV      16'h0F3C
`define FLOOR_STEP_MV      16'h0064
// Floor decoded from the reset code 0110 with tracking off: 4500 mV.
`define FLOOR_RST_MV       16'h1194

// Battery tracking offsets in mV: 200, 250, 300.
`define TRACK_MV_1         16'h00C8
`define TRACK_MV_2         16'h00FA
`define TRACK_MV_3         16'h012C

// Safety timer base durations in hours.
`define TIMER_HRS_SHORT    6'h0A
`define TIMER_HRS_LONG     6'h14

// Switch-off delay in seconds and the clock rate in Hz.
`define SWITCH_OFF_DELAY_S 10
`define CLK_HZ             100000000

`endif

// File: verilog/charger_ctrl_pkg.sv
package charger_ctrl_pkg;

	// Second control register layout.
	typedef struct packed {
		logic [1:0] input_overvoltage_sel;
		logic [1:0] boost_voltage_sel;
		logic [3:0] input_voltage_floor;
	} ctrl_two_type;

	// Third control register layout.
	typedef struct packed {
		logic       force_source_detect;
		logic       timer_half_rate_en;
		logic       battery_switch_off;
		logic       sysreset_with_adapter;
		logic       battery_switch_off_delay;
		logic       full_sysreset_en;
		logic [1:0] floor_battery_track;
	} ctrl_three_type;

	// Analog settings presented to the regulation loops, in mV.
	typedef struct packed {
		logic [15:0] input_overvoltage_threshold;
		logic [15:0] boost_mv;
		logic [15:0] floor_mv;
	} settings_type;

endpackage : charger_ctrl_pkg

// File: verilog/charger_control_registers_two_three.sv
`include "charger_ctrl_map.svh"

module charger_control_registers_two_three #(
	parameter int unsigned DELAY_CYCLES = `SWITCH_OFF_DELAY_S * `CLK_HZ
) (
	input  wire logic                        i_clk,
	input  wire logic                        i_srst,
	input  wire logic                        i_reg_reset,
	input  wire logic                        i_wdog_expire,
	input  wire logic                        i_wr_en,
	input  wire logic                        i_rd_en,
	input  wire logic [7:0]                  i_addr,
	input  wire logic [7:0]                  i_wr_data,
	input  wire logic                        i_detect_done,
	input  wire logic                        i_adapter_present,
	input  wire logic                        i_in_regulation,
	input  wire logic                        i_jeita_reduced,
	input  wire logic                        i_thermal_reg,
	input  wire logic                        i_timer_10h,
	input  wire logic [15:0]                 i_vbat_mv,
	output logic [7:0]                       o_rd_data,
	output charger_ctrl_pkg::settings_type   o_settings,
	output logic                             o_force_detect,
	output logic                             o_timer_half_rate,
	output logic [5:0]                       o_safety_hours,
	output logic                             o_battery_path_off,
	output logic                             o_sysreset_start
);
	import charger_ctrl_pkg::*;

	// Stored registers and their next values.
	ctrl_two_type   two_q;      // Second control register.
	ctrl_two_type   two_d;
	ctrl_three_type three_q;    // Third control register.
	ctrl_three_type three_d;
	logic [31:0]    cnt_q;      // Switch-off delay counter.
	logic [31:0]    cnt_d;

	// Address decode of the register port.
	wire logic      wr_two   = i_wr_en && (i_addr == `ADDR_CTRL_TWO);
	wire logic      wr_three = i_wr_en && (i_addr == `ADDR_CTRL_THREE);
	wire logic      reg_rst  = i_reg_reset;
	wire logic [7:0] rst3    = `RST_CTRL_THREE;

	// Second register: register reset, else host write, else hold.
	assign two_d = reg_rst  ? ctrl_two_type'(`RST_CTRL_TWO) :
	               wr_two   ? ctrl_two_type'(i_wr_data)     :
	               two_q;

	// Third register: the write lands first, then the watchdog restores
	// its three fields, then detection completion clears bit 7.
	wire logic [7:0] three_wr = wr_three ? i_wr_data : 8'(three_q);
	wire logic [7:0] three_wd = i_wdog_expire ?
		{rst3[7:6], three_wr[5:3], rst3[2], three_wr[1:0]} :
		three_wr;
	// A host write of 1 in the same cycle as completion keeps the bit set,
	// so a fresh request is not swallowed by the previous detection.
	wire logic det_clr = i_detect_done && !(wr_three && i_wr_data[7]);
	wire logic [7:0] three_nx = det_clr ?
		{1'b0, three_wd[6:0]} : three_wd;
	assign three_d = reg_rst ? ctrl_three_type'(rst3) :
	                 ctrl_three_type'(three_nx);

	// Delay counter runs only while switch-off is requested; clearing the
	// bit aborts a pending turn-off.
	wire logic cnt_done = (cnt_q == DELAY_CYCLES);
	assign cnt_d = !three_q.battery_switch_off ? 32'h0000_0000 :
	               cnt_done ? cnt_q : cnt_q + 32'h0000_0001;

	// Battery switch turns off at once, or after the delay.
	wire logic off_d = three_q.battery_switch_off &&
		(!three_q.battery_switch_off_delay || cnt_done);

	// Full reset starts once the switch is off, with the adapter present or absent as the stored bit selects.
	// Order of host writes (adapter bit first) is up to the host; the
	// stored adapter bit, checked every cycle, is what counts here.
	wire logic adapter_ok = three_q.sysreset_with_adapter ?
		i_adapter_present : !i_adapter_present;
	wire logic sysrst_d = three_q.full_sysreset_en &&
		three_q.battery_switch_off && o_battery_path_off && adapter_ok;

	// Safety timer slows when any reduced-rate condition holds.
	wire logic half_d = three_q.timer_half_rate_en &&
		(i_in_regulation || i_jeita_reduced || i_thermal_reg);
	wire logic [5:0] hrs_base = i_timer_10h ?
		`TIMER_HRS_SHORT : `TIMER_HRS_LONG;
	wire logic [5:0] hrs_d = half_d ? {hrs_base[4:0], 1'b0} : hrs_base;

	// Analog setting decodes.
	wire logic [15:0] ovp_mv =
		(two_q.input_overvoltage_sel == 2'h0) ? `OVP_MV_0 :
		(two_q.input_overvoltage_sel == 2'h1) ? `OVP_MV_1 :
		(two_q.input_overvoltage_sel == 2'h2) ? `OVP_MV_2 : `OVP_MV_3;
	wire logic [15:0] boost_mv =
		(two_q.boost_voltage_sel == 2'h0) ? `BOOST_MV_0 :
		(two_q.boost_voltage_sel == 2'h1) ? `BOOST_MV_1 :
		(two_q.boost_voltage_sel == 2'h2) ? `BOOST_MV_2 : `BOOST_MV_3;
	wire logic [15:0] floor_reg_mv = `FLOOR_BASE_MV +
		(16'(two_q.input_voltage_floor) * `FLOOR_STEP_MV);
	wire logic [15:0] track_off =
		(three_q.floor_battery_track == 2'h1) ? `TRACK_MV_1 :
		(three_q.floor_battery_track == 2'h2) ? `TRACK_MV_2 : `TRACK_MV_3;
	wire logic [15:0] track_mv = i_vbat_mv + track_off;
	// Tracking off means the register value alone sets the floor.
	wire logic [15:0] floor_mv =
		((three_q.floor_battery_track != 2'h0) && (track_mv > floor_reg_mv))
		? track_mv : floor_reg_mv;

	// Read mux; unmapped addresses read as zero.
	wire logic [7:0] rd_mux =
		(i_addr == `ADDR_CTRL_TWO)   ? 8'(two_q)   :
		(i_addr == `ADDR_CTRL_THREE) ? 8'(three_q) : 8'h00;

	// Configuration state; i_srst acts as a register reset too.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			two_q   <= ctrl_two_type'(`RST_CTRL_TWO);
			three_q <= ctrl_three_type'(`RST_CTRL_THREE);
			cnt_q   <= 32'h0000_0000;
		end else begin
			two_q   <= two_d;
			three_q <= three_d;
			cnt_q   <= cnt_d;
		end
	end

	// Registered outputs.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_rd_data          <= 8'h00;
			// Settings come out of reset already decoded from the reset
			// codes, so the loops never see a zero threshold after release.
			o_settings         <= '{`OVP_MV_3, `BOOST_MV_2, `FLOOR_RST_MV};
			o_force_detect     <= 1'b0;
			o_timer_half_rate  <= 1'b0;
			o_safety_hours     <= `TIMER_HRS_SHORT;
			o_battery_path_off <= 1'b0;
			o_sysreset_start   <= 1'b0;
		end else begin
			o_rd_data          <= i_rd_en ? rd_mux : o_rd_data;
			o_settings         <= '{ovp_mv, boost_mv, floor_mv};
			o_force_detect     <= three_q.force_source_detect &&
			                      i_adapter_present;
			o_timer_half_rate  <= half_d;
			o_safety_hours     <= hrs_d;
			o_battery_path_off <= off_d;
			o_sysreset_start   <= sysrst_d;
		end
	end

	// Register reset restores both registers whole.
	AST_REG_RESET: assert property (@(posedge i_clk) disable iff (i_srst)
		i_reg_reset |=> (8'(two_q) == 8'hE6) && (8'(three_q) == 8'h4C))
		else $error("register reset did not restore defaults");

	// Watchdog keeps bits 5, 4, 3, 1, 0 untouched.
	AST_WDOG_KEEP: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_wdog_expire && !wr_three && !i_reg_reset) |=>
		(8'(three_q) & 8'h3B) == ($past(8'(three_q)) & 8'h3B))
		else $error("watchdog changed a register-reset-only bit");

	// Watchdog restores bits 7, 6, 2.
	AST_WDOG_RESTORE: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_wdog_expire && !i_reg_reset) |=>
		!three_q.force_source_detect && three_q.timer_half_rate_en &&
		three_q.full_sysreset_en)
		else $error("watchdog did not restore its fields");

	// Completion clears the detect request.
	AST_DETECT_CLEAR: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_detect_done && !(wr_three && i_wr_data[7])) |=>
		!three_q.force_source_detect)
		else $error("detect bit not cleared on completion");

	// Immediate mode turns the switch off one edge after the stored bit is seen.
	AST_IMMEDIATE_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
		(three_q.battery_switch_off && !three_q.battery_switch_off_delay)
		|=> o_battery_path_off)
		else $error("switch not off in immediate mode");

	// Delayed mode holds the switch on for the first cycles.
	AST_DELAYED_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
		($rose(three_q.battery_switch_off) && three_q.battery_switch_off_delay
		 && (DELAY_CYCLES > 2)) |=> !o_battery_path_off [*2])
		else $error("switch turned off before the delay");

	// No system reset while the enable is clear.
	AST_SYSRST_EN: assert property (@(posedge i_clk) disable iff (i_srst)
		!three_q.full_sysreset_en |=> !o_sysreset_start)
		else $error("system reset started while disabled");

	// Overvoltage decode at the reset code.
	AST_OVP: assert property (@(posedge i_clk) disable iff (i_srst)
		(two_q.input_overvoltage_sel == 2'h3) |=>
		(o_settings.input_overvoltage_threshold == 16'h3778))
		else $error("overvoltage threshold decode wrong");

	// Boost decode at the default code.
	AST_BOOST: assert property (@(posedge i_clk) disable iff (i_srst)
		(two_q.boost_voltage_sel == 2'h2) |=> (o_settings.boost_mv == 16'h1388))
		else $error("boost voltage decode wrong");

	// Floor never below the register value.
	AST_FLOOR: assert property (@(posedge i_clk) disable iff (i_srst)
		1'b1 |=> (o_settings.floor_mv >= $past(floor_reg_mv)))
		else $error("floor below register value");

	// Half rate doubles the safety timer duration.
	AST_HALF: assert property (@(posedge i_clk) disable iff (i_srst)
		(half_d && !i_timer_10h) |=> (o_safety_hours == 6'h28))
		else $error("half rate did not double the timer");

endmodule : charger_control_registers_two_three

// File: testbench/charger_host_model.sv
// Host on the register port: one strobed access at a time.
module charger_host_model (
	input  wire logic       i_clk,
	output logic            o_wr_en,
	output logic            o_rd_en,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wr_data,
	input  wire logic [7:0] i_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle at time zero, strobes low.
	initial begin
		o_wr_en   = 1'b0;
		o_rd_en   = 1'b0;
		o_addr    = 8'h00;
		o_wr_data = 8'h00;
	end

	// Once released, address and data go inverted so no stale value helps.
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge i_clk);
		o_wr_en   <= wr;
		o_rd_en   <= ~wr;
		o_addr    <= a;
		o_wr_data <= d;
		@(posedge i_clk);
		o_wr_en   <= 1'b0;
		o_rd_en   <= 1'b0;
		o_addr    <= ~a;
		o_wr_data <= ~d;
	endtask : access

	// Read data is registered, so it is taken one edge after the strobe.
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		access(1'b0, a, 8'h00);
		@(posedge i_clk);
		#1 d = i_rd_data;
	endtask : read

	// Arm the adapter bit first; the switch-off bit only in a later write.
	task automatic full_reset_seq();
		access(1'b1, 8'h07, 8'h14);
		access(1'b1, 8'h07, 8'h34);
	endtask : full_reset_seq
endmodule : charger_host_model

// File: testbench/charger_control_registers_two_three_tb.sv
`include "charger_ctrl_map.svh"

module charger_control_registers_two_three_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import charger_ctrl_pkg::*;

	logic         clk, srst, rr, wdog, done, adp, in_reg, jeita, therm;
	logic         t10h, wr_en, rd_en, half, force_det, off, sys_start;
	logic [7:0]   addr, wdata, rdata;
	logic [15:0]  vbat;
	logic [5:0]   hours;
	settings_type st;
	int           miscompares, checks_done;

	// Short switch-off delay keeps the run brief.
	charger_control_registers_two_three #(.DELAY_CYCLES(20)) DUT (
		.i_clk(clk), .i_srst(srst), .i_reg_reset(rr),
		.i_wdog_expire(wdog), .i_wr_en(wr_en), .i_rd_en(rd_en),
		.i_addr(addr), .i_wr_data(wdata), .i_detect_done(done),
		.i_adapter_present(adp), .i_in_regulation(in_reg),
		.i_jeita_reduced(jeita), .i_thermal_reg(therm),
		.i_timer_10h(t10h), .i_vbat_mv(vbat), .o_rd_data(rdata),
		.o_settings(st), .o_force_detect(force_det),
		.o_timer_half_rate(half), .o_safety_hours(hours),
		.o_battery_path_off(off), .o_sysreset_start(sys_start));

	charger_host_model host (.i_clk(clk), .o_wr_en(wr_en),
		.o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wdata),
		.i_rd_data(rdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.read(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask : rdchk

	// Derived outputs lag the register by one cycle, o_sysreset_start by two; three is ample.
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask : settle

	task automatic reg_rst();
		@(posedge clk) rr <= 1'b1;
		@(posedge clk) rr <= 1'b0;
	endtask : reg_rst

	task automatic t_reset();
		rdchk(8'h06, 8'hE6);
		rdchk(8'h07, 8'h4C);
		rdchk(8'h08, 8'h00);
		chk(st.input_overvoltage_threshold, `OVP_MV_3);
		chk(st.boost_mv, `BOOST_MV_2);
		chk(st.floor_mv, 16'h1194);
		$display("test reset done");
	endtask : t_reset

	// Floor codes 0, 5, A, F cover both ends of the range.
	task automatic t_fields();
		logic [15:0] ov[4] = '{`OVP_MV_0, `OVP_MV_1, `OVP_MV_2, `OVP_MV_3};
		logic [15:0] bo[4] = '{`BOOST_MV_0, `BOOST_MV_1, `BOOST_MV_2,
			`BOOST_MV_3};
		for (int i = 0; i < 4; i++) begin
			host.access(1'b1, 8'h06, {4{i[1:0]}});
			settle();
			chk(st.input_overvoltage_threshold, ov[i]);
			chk(st.boost_mv, bo[i]);
			chk(st.floor_mv, 16'h0F3C + 16'h0064 * {i[1:0], i[1:0]});
			rdchk(8'h06, {4{i[1:0]}});
		end
		$display("test fields done");
	endtask : t_fields

	task automatic t_track();
		logic [15:0] ex[4] = '{16'h0F3C, 16'h1450, 16'h1482, 16'h14B4};
		@(posedge clk) vbat <= 16'h1388;
		host.access(1'b1, 8'h06, 8'hE0);
		for (int i = 0; i < 4; i++) begin
			host.access(1'b1, 8'h07, {6'h13, i[1:0]});
			settle();
			chk(st.floor_mv, ex[i]);
		end
		@(posedge clk) vbat <= 16'h0BB8;
		settle();
		chk(st.floor_mv, 16'h0F3C);
		$display("test track done");
	endtask : t_track

	task automatic t_half();
		@(posedge clk) t10h <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk) {in_reg, jeita, therm} <= 3'b100 >> k;
			settle();
			chk(half, 1'b1);
			chk(hours, 6'h14);
		end
		@(posedge clk) t10h <= 1'b0;
		settle();
		chk(hours, 6'h28);
		host.access(1'b1, 8'h07, 8'h0C);
		settle();
		chk(hours, 6'h14);
		@(posedge clk) {in_reg, jeita, therm} <= 3'b000;
		$display("test half rate done");
	endtask : t_half

	task automatic t_detect_wdog();
		@(posedge clk) adp <= 1'b1;
		host.access(1'b1, 8'h07, 8'h8C);
		settle();
		chk(force_det, 1'b1);
		@(posedge clk) done <= 1'b1;
		@(posedge clk) done <= 1'b0;
		rdchk(8'h07, 8'h0C);
		chk(force_det, 1'b0);
		@(posedge clk) adp <= 1'b0;
		host.access(1'b1, 8'h06, 8'h15);
		host.access(1'b1, 8'h07, 8'hA3);
		@(posedge clk) wdog <= 1'b1;
		@(posedge clk) wdog <= 1'b0;
		rdchk(8'h07, 8'h67);
		rdchk(8'h06, 8'h15);
		chk(off, 1'b1);
		reg_rst();
		rdchk(8'h06, 8'hE6);
		rdchk(8'h07, 8'h4C);
		chk(off, 1'b0);
		$display("test detect and watchdog done");
	endtask : t_detect_wdog

	// The delayed turn-off is waited for under a bound.
	task automatic t_ship();
		int n = 0;
		host.access(1'b1, 8'h07, 8'h28);
		#1;
		while (off !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 60) begin
			miscompares++;
			$display("mismatch at %0t: switch-off wait timed out", $time);
			wrap_up();
		end
		chk(16'(n >= 20 && n <= 24), 16'h0001);
		reg_rst();
		host.access(1'b1, 8'h07, 8'h20);
		settle();
		chk(off, 1'b1);
		chk(sys_start, 1'b0);
		$display("test ship mode done");
	endtask : t_ship

	task automatic t_sysrst();
		reg_rst();
		adp <= 1'b1;
		host.full_reset_seq();
		settle();
		chk(sys_start, 1'b1);
		@(posedge clk) adp <= 1'b0;
		settle();
		chk(sys_start, 1'b0);
		reg_rst();
		host.access(1'b1, 8'h07, 8'h24);
		settle();
		chk(sys_start, 1'b1);
		$display("test system reset done");
	endtask : t_sysrst

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	// Reset held three cycles, then each scenario in turn.
	initial begin
		srst = 1'b1;
		{rr, wdog, done, adp, in_reg, jeita, therm, t10h} = 8'h01;
		vbat = 16'h0E10;
		miscompares = 0;
		checks_done = 0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_fields();
		t_track();
		t_half();
		t_detect_wdog();
		t_ship();
		t_sysrst();
		wrap_up();
	end
endmodule : charger_control_registers_two_three_tb
